// ==== rtl/expander_pkg.sv ====
// Constants shared by the serial port expander frame logic.
package expander_pkg;
	localparam int FRAME_BITS = 16;
	localparam int ADDR_BITS  = 7;
	localparam int DATA_BITS  = 8;
	localparam int PORT_COUNT = 10;
	localparam int RW_BIT     = 15;
	localparam int ADDR_MSB   = 14;
	localparam int ADDR_LSB   = 8;
	localparam logic [6:0] ADDR_PORT_LAST = 7'h09;
	localparam logic [6:0] ADDR_ALL_PORTS = 7'h0A;
	localparam logic [6:0] ADDR_INPUT_LO  = 7'h0E;
	localparam logic [6:0] ADDR_INPUT_HI  = 7'h0F;
	localparam logic [7:0] LEVEL_RESET    = 8'h01;
	localparam logic [7:0] LEVEL_LOW      = 8'h00;
	localparam logic [7:0] READ_NONE      = 8'h00;
endpackage : expander_pkg

// ==== rtl/level_store.sv ====
// Memory holding the ten port level registers, registered read data.
`timescale 1ns/10ps
module level_store (
	// Clock and reset.
	input  wire logic                             core_clk,
	input  wire logic                             reset_n,
	// Write side; broadcast writes every entry.
	input  wire logic                             wr_en,
	input  wire logic                             wr_all,
	input  wire logic [3:0]                       wr_idx,
	input  wire logic [expander_pkg::DATA_BITS-1:0] wr_data,
	// Read side.
	input  wire logic [3:0]                       rd_idx,
	output logic [expander_pkg::DATA_BITS-1:0]      rd_data,
	// Open-drain pull-down per port.
	output logic [expander_pkg::PORT_COUNT-1:0]     pull_low
);
	import expander_pkg::*;

	logic [DATA_BITS-1:0] mem_q [PORT_COUNT];

	// ==========================================================
	// Storage
	genvar g;
	generate
		for (g = 0; g < PORT_COUNT; g++) begin : g_port
			always_ff @(posedge core_clk) begin
				if (!reset_n) begin
					mem_q[g]    <= LEVEL_RESET;
					pull_low[g] <= 1'b0;
				end else begin
					if (wr_en && (wr_all || wr_idx == 4'(g))) begin
						mem_q[g]    <= wr_data;
						pull_low[g] <= (wr_data == LEVEL_LOW);
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rd_data <= READ_NONE;
		end else if (rd_idx < 4'(PORT_COUNT)) begin
			rd_data <= mem_q[rd_idx];
		end else begin
			rd_data <= READ_NONE;
		end
	end
endmodule : level_store

// ==== rtl/expander_frame.sv ====
// Serial frame logic of a ten-port I/O expander.
`timescale 1ns/10ps
module expander_frame (
	// Clock and reset.
	input  wire logic                               core_clk,
	input  wire logic                               reset_n,
	// Serial link pins.
	input  wire logic                               sclk,
	input  wire logic                               cs_n,
	input  wire logic                               din,
	output logic                                    dout,
	// Port pins, open drain.
	input  wire logic [expander_pkg::PORT_COUNT-1:0] port_in,
	output logic [expander_pkg::PORT_COUNT-1:0]      port_out,
	output logic [expander_pkg::PORT_COUNT-1:0]      port_oe,
	// Last latched command.
	output logic [expander_pkg::FRAME_BITS-1:0]      cmd_latch
);
	import expander_pkg::*;

	// Index width into the port level store.
	localparam int IDX_BITS = $clog2(PORT_COUNT);

	// ==========================================================
	// Synchronisers
	logic [1:0]            sclk_s_q, cs_s_q, din_s_q;
	logic [PORT_COUNT-1:0] pin_a_q, pin_b_q;
	logic                  sclk_d1_q, cs_d1_q;

	// The serial clock gets a third stage so that its edges can be seen.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			sclk_s_q  <= '0;
			sclk_d1_q <= 1'b0;
		end else begin
			sclk_s_q  <= {sclk_s_q[0], sclk};
			sclk_d1_q <= sclk_s_q[1];
		end
	end

	// Select resets to its idle high level, so no false rise follows reset.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cs_s_q  <= '1;
			cs_d1_q <= 1'b1;
		end else begin
			cs_s_q  <= {cs_s_q[0], cs_n};
			cs_d1_q <= cs_s_q[1];
		end
	end

	// Data is delayed as much as the clock, so each bit is taken in step.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			din_s_q <= '0;
		end else begin
			din_s_q <= {din_s_q[0], din};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pin_a_q <= '0;
			pin_b_q <= '0;
		end else begin
			pin_a_q <= port_in;
			pin_b_q <= pin_a_q;
		end
	end

	// ==========================================================
	// Edge detection
	// Edges compare the second synchroniser stage against the third.
	logic sclk_rise, sclk_fall, cs_rise, selected;
	assign sclk_rise = sclk_s_q[1] && !sclk_d1_q;
	assign sclk_fall = !sclk_s_q[1] && sclk_d1_q;
	assign cs_rise   = cs_s_q[1] && !cs_d1_q;
	assign selected  = !cs_s_q[1] && !cs_d1_q;

	// ==========================================================
	// Shift register and command latch
	logic [FRAME_BITS-1:0] shift_q;
	logic                  load_pend_q;
	logic [DATA_BITS-1:0]  rd_byte;
	logic [DATA_BITS-1:0]  store_rd;
	logic [DATA_BITS-1:0]  input_rd;

	// A pending read load wins over a shift; no clock edge comes that soon.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			shift_q <= '0;
		end else if (load_pend_q) begin
			shift_q[DATA_BITS-1:0] <= rd_byte;
		end else if (selected && sclk_rise) begin
			shift_q <= {shift_q[FRAME_BITS-2:0], din_s_q[1]};
		end
	end

	// The latch moves only when select rises, never while bits shift in.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cmd_latch <= '0;
		end else if (cs_rise) begin
			cmd_latch <= shift_q;
		end
	end

	// Bit 15 leaves on the falling edge half a clock after it was sampled.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			dout <= 1'b0;
		end else if (sclk_fall) begin
			dout <= shift_q[FRAME_BITS-1];
		end
	end

	// ==========================================================
	// Command decode at select rising
	logic [ADDR_BITS-1:0] addr;
	logic                 is_read;
	logic                 wr_en, wr_all;
	logic [IDX_BITS-1:0]  wr_idx, rd_idx;

	assign addr    = shift_q[ADDR_MSB:ADDR_LSB];
	assign is_read = shift_q[RW_BIT];

	// True for the addresses that hold the level of one port each.
	function automatic logic is_port(input logic [ADDR_BITS-1:0] a);
		return a <= ADDR_PORT_LAST;
	endfunction : is_port

	// Only per-port and broadcast addresses write; the rest are ignored.
	assign wr_en  = cs_rise && !is_read
	              && (is_port(addr) || addr == ADDR_ALL_PORTS);
	assign wr_all = addr == ADDR_ALL_PORTS;
	assign wr_idx = addr[IDX_BITS-1:0];
	assign rd_idx = is_port(addr) ? addr[IDX_BITS-1:0] : '0;

	// The store read lags one cycle, so the load is applied one cycle late.
	logic [ADDR_BITS-1:0] rd_addr_q;
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			load_pend_q <= 1'b0;
			rd_addr_q   <= '0;
		end else begin
			load_pend_q <= cs_rise && is_read;
			if (cs_rise) begin
				rd_addr_q <= addr;
			end
		end
	end

	// Input levels are ready by the cycle in which the load falls due.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			input_rd <= READ_NONE;
		end else if (addr == ADDR_INPUT_LO) begin
			input_rd <= pin_b_q[DATA_BITS-1:0];
		end else begin
			input_rd <= DATA_BITS'(pin_b_q[PORT_COUNT-1:DATA_BITS]);
		end
	end

	// Selects the byte to load; unmapped addresses read as zero.
	always_comb begin
		if (is_port(rd_addr_q) || rd_addr_q == ADDR_ALL_PORTS) begin
			rd_byte = store_rd;
		end else if (rd_addr_q == ADDR_INPUT_LO
		          || rd_addr_q == ADDR_INPUT_HI) begin
			rd_byte = input_rd;
		end else begin
			rd_byte = READ_NONE;
		end
	end

	// ==========================================================
	// Port level store
	logic [PORT_COUNT-1:0] pull_low;

	// The store's pull-downs pass one more register on their way out.
	level_store u_store (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.wr_en    (wr_en),
		.wr_all   (wr_all),
		.wr_idx   (wr_idx),
		.wr_data  (shift_q[DATA_BITS-1:0]),
		.rd_idx   (rd_idx),
		.rd_data  (store_rd),
		.pull_low (pull_low)
	);

	// ==========================================================
	// Port drive
	// The pins only ever sink current; the enable alone sets the level.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			port_out <= '0;
			port_oe  <= '0;
		end else begin
			port_out <= '0;
			port_oe  <= pull_low;
		end
	end
endmodule : expander_frame

// ==== sim/expander_frame_monitor.sv ====
// Port checker for the expander frame logic.
`timescale 1ns/10ps
module expander_frame_monitor (
	// Watched pins.
	input wire logic	core_clk,
	input wire logic	reset_n,
	input wire logic	sclk,
	input wire logic	cs_n,
	input wire logic	dout,
	input wire logic [expander_pkg::PORT_COUNT-1:0]	port_out,
	input wire logic [expander_pkg::PORT_COUNT-1:0]	port_oe,
	input wire logic [expander_pkg::FRAME_BITS-1:0]	cmd_latch
);
	import expander_pkg::*;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	sequence wr_taken;
		$changed(cmd_latch) && !cmd_latch[RW_BIT];
	endsequence
	sequence rd_taken;
		$changed(cmd_latch) && cmd_latch[RW_BIT];
	endsequence
	a_pins_open_drain: assert property (
		port_out == 10'h000) else $error("port driven high");
	a_latch_at_rise: assert property (
		$changed(cmd_latch) |-> cs_n && !$past(cs_n, 8))
		else $error("latch moved outside select rise");
	a_oe_at_rise: assert property (
		$changed(port_oe) |-> cs_n && !$past(cs_n, 8))
		else $error("port moved outside select rise");
	a_dout_on_fall: assert property (
		$changed(dout) |-> !sclk) else $error("dout moved with clock high");
	a_write_one_port: assert property (
		wr_taken ##0 cmd_latch[14:8] <= ADDR_PORT_LAST |-> ##[1:3]
		port_oe[cmd_latch[11:8]] == (cmd_latch[7:0] == LEVEL_LOW))
		else $error("port write lost");
	a_write_all_ports: assert property (
		wr_taken ##0 cmd_latch[14:8] == ADDR_ALL_PORTS |-> ##[1:3]
		port_oe == {PORT_COUNT{cmd_latch[7:0] == LEVEL_LOW}})
		else $error("broadcast write lost");
	a_stray_write: assert property (
		wr_taken ##0 cmd_latch[14:8] > ADDR_ALL_PORTS |=> $stable(port_oe)[*4])
		else $error("unmapped write changed ports");
	a_read_keeps_ports: assert property (
		rd_taken |=> $stable(port_oe)[*4]) else $error("read changed ports");
endmodule : expander_frame_monitor
bind expander_frame expander_frame_monitor mon (.core_clk(core_clk),
	.reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .dout(dout),
	.port_out(port_out), .port_oe(port_oe), .cmd_latch(cmd_latch));

// ==== sim/serial_host.sv ====
// Host model that shifts frames over the serial link.
`timescale 1ns/10ps
module serial_host (
	// Clock.
	input wire logic	core_clk,
	// Serial link.
	output logic	sclk,
	output logic	cs_n,
	output logic	din,
	input wire logic	dout
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	task automatic pause(input int n);
		repeat (n) @(negedge core_clk);
	endtask : pause
	// Sends the low n bits of w; rx keeps the last sixteen dout bits.
	task automatic xfer(input logic [19:0] w, input int n, input logic sel,
		output logic [15:0] rx);
		cs_n <= ~sel;
		pause(4);
		for (int i = n - 1; i >= 0; i--) begin
			din <= w[i];
			pause(4);
			rx = {rx[14:0], dout};
			sclk <= 1'b1;
			pause(4);
			sclk <= 1'b0;
		end
		pause(4);
		cs_n <= 1'b1;
		din <= ~din;
		pause(8);
	endtask : xfer
endmodule : serial_host

// ==== sim/serial_port_expander_frame_logic_bench.sv ====
// Self-checking bench for the expander frame logic.
`timescale 1ns/10ps
module serial_port_expander_frame_logic_bench;
	import expander_pkg::*;
	logic	core_clk = 1'b0;
	logic	reset_n = 1'b0;
	logic	sclk, cs_n, din, dout;
	logic [PORT_COUNT-1:0]	port_in = 10'h2A5;
	logic [PORT_COUNT-1:0]	port_out, port_oe;
	logic [FRAME_BITS-1:0]	cmd_latch, rx;
	int	error_cnt = 0;
	int	checks = 0;
	logic [15:0] frm [11] = '{16'h0A00, 16'h0A01, 16'h0300, 16'h0900,
		16'h0B00, 16'h0305, 16'h8EFF, 16'h8F3C, 16'h8A00, 16'h8B11, 16'h0901};
	logic [9:0] oe [11] = '{10'h3FF, 10'h000, 10'h008, 10'h208, 10'h208,
		10'h200, 10'h200, 10'h200, 10'h200, 10'h200, 10'h000};
	logic [7:0] rd [11] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
		8'h05, 8'hA5, 8'h02, 8'h01, 8'h00};
	always #10 core_clk = ~core_clk;
	serial_host host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n),
		.din(din), .dout(dout));
	expander_frame dut (.core_clk(core_clk), .reset_n(reset_n), .sclk(sclk),
		.cs_n(cs_n), .din(din), .dout(dout), .port_in(port_in),
		.port_out(port_out), .port_oe(port_oe), .cmd_latch(cmd_latch));
	function automatic logic tally(input logic bad);
		checks++;
		return bad;
	endfunction : tally
	task automatic fail(input string what);
		error_cnt++;
		$display("mismatch at %0t: %s", $time, what);
	endtask : fail
	task automatic complete_run;
		$display("mismatches %0d, comparisons %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (20) @(negedge core_clk);
		if (tally(port_oe !== 10'h000 || cmd_latch !== 16'h0000
			|| port_out !== '0 || dout !== 1'b0)) fail("reset");
		reset_n <= 1'b1;
		host.pause(4);
		for (int i = 0; i < 11; i++) begin
			host.xfer({4'h0, frm[i]}, 16, 1'b1, rx);
			if (tally(cmd_latch !== frm[i] || port_oe !== oe[i]
				|| port_out !== '0)) fail("write");
			if (i > 0 && tally(rx !== {frm[i-1][15:8], rd[i]})) fail("read");
		end
		host.xfer(20'hF_0300, 20, 1'b1, rx);
		if (tally(cmd_latch !== 16'h0300 || port_oe !== 10'h008)) fail("long");
		host.xfer(20'h0_0202, 16, 1'b1, rx);
		host.xfer(20'h0_0000, 8, 1'b1, rx);
		if (tally(cmd_latch !== 16'h0200 || port_oe !== 10'h00C)) fail("short");
		host.xfer(20'h0_0A00, 16, 1'b0, rx);
		host.xfer(20'h0_0000, 0, 1'b1, rx);
		if (tally(cmd_latch !== 16'h0200 || port_oe !== 10'h00C)) fail("idle");
		reset_n <= 1'b0;
		host.pause(2);
		if (tally(port_oe !== 10'h000 || cmd_latch !== 16'h0000))
			fail("second reset");
		reset_n <= 1'b1;
		host.pause(4);
		host.xfer(20'h0_8200, 16, 1'b1, rx);
		host.xfer(20'h0_8900, 16, 1'b1, rx);
		if (tally(rx !== {8'h82, LEVEL_RESET})) fail("reset levels");
		if (tally(cmd_latch !== 16'h8900)) fail("read latch");
		complete_run();
	end
endmodule : serial_port_expander_frame_logic_bench
